//--- logic/piw_ctrl.sv
// Pin interrupt flags, trigger logic and idle/stop control with an APB slave.
// Assumes pins are asynchronous, core acknowledges are synchronous pulses.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module piw_ctrl
	import piw_pkg::*;
#(
	parameter int WARM_CYC = PIW_WARM_CYC
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_pin_zero,
	input  wire logic        ext_pin_one,
	input  wire logic        ext_pin_two,
	input  wire logic [7:0]  port1_pins,
	input  wire piw_core_s   core_in,
	output piw_stat_s        stat_out,
	output logic             clk_run
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [10:0] s1_r;
	logic [10:0] s2_r;
	logic [10:0] s3_r;
	logic [10:0] pin_r;
	logic [10:0] raw;

	assign raw = {port1_pins, ext_pin_two, ext_pin_one, ext_pin_zero};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_r <= 11'h7FF;
			s2_r <= 11'h7FF;
			s3_r <= 11'h7FF;
		end
		else
		begin
			s1_r <= raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A change counts once the second and third stage agree.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_r <= 11'h7FF;
		else
			pin_r <= (s2_r & s3_r) | (pin_r & (s2_r ^ s3_r));
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0] pwr_r;
	logic [7:0] timer_and_ext_int_control_r;
	logic [7:0] flg_r;
	logic [7:0] en_r;
	logic [7:0] wk_r;
	piw_mode_e  mode_r;
	logic [15:0] warm_r;

	logic [7:0] idx;
	logic       wr;
	logic       sampling;
	logic       fall0;
	logic       fall1;
	logic       fall2;
	logic       p1_chg;
	logic [7:0] wd;

	assign idx      = paddr[9:2];
	assign wd       = pwdata[7:0];
	assign wr       = psel & penable & pwrite & (paddr[11:10] == 2'b00) & (paddr[1:0] == 2'b00);
	assign sampling = (mode_r == PIW_RUN) || (mode_r == PIW_IDLE);
	assign fall0    = sampling & pin_r[0] & ~(s2_r[0] & s3_r[0]) & ~s2_r[0] & ~s3_r[0];
	assign fall1    = sampling & pin_r[1] & ~s2_r[1] & ~s3_r[1];
	assign fall2    = sampling & pin_r[2] & ~s2_r[2] & ~s3_r[2];
	assign p1_chg   = |((pin_r[10:3] ^ raw[10:3]) & wk_r);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			en_r <= PIW_RST_BYTE;
		else if (wr && idx == PIW_EN_IDX)
			en_r <= wd;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wk_r <= PIW_RST_BYTE;
		else if (wr && idx == PIW_WK_IDX)
			wk_r <= wd;
	end

	// Edge flags: hardware set wins over clear.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_and_ext_int_control_r <= PIW_RST_BYTE;
		else
		begin
			if (wr && idx == PIW_TIMER_AND_EXT_INT_CONTROL_IDX)
				timer_and_ext_int_control_r <= wd;
			if (core_in.vec_ack[0] && timer_and_ext_int_control_r[PIW_T_IT0])
				timer_and_ext_int_control_r[PIW_T_IE0] <= 1'b0;
			if (core_in.vec_ack[1] && timer_and_ext_int_control_r[PIW_T_IT1])
				timer_and_ext_int_control_r[PIW_T_IE1] <= 1'b0;
			if (fall0)
				timer_and_ext_int_control_r[PIW_T_IE0] <= 1'b1;
			if (fall1)
				timer_and_ext_int_control_r[PIW_T_IE1] <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flg_r <= PIW_RST_BYTE;
		else
		begin
			if (wr && idx == PIW_FLG_IDX)
				flg_r <= flg_r & wd & PIW_FLG_MASK;
			if (core_in.vec_ack[2])
				flg_r[PIW_F_IE2] <= 1'b0;
			if (core_in.p1_ack)
				flg_r[PIW_F_P1] <= 1'b0;
			if (fall2)
				flg_r[PIW_F_IE2] <= 1'b1;
			if (p1_chg && mode_r != PIW_STOP)
				flg_r[PIW_F_P1] <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt requests
	// ---------------------------------------------------------------
	logic       ea;
	logic [3:0] src;
	logic       any_irq;
	logic       lvl0;
	logic       lvl1;
	logic       stop_wake;
	logic       p1_wake_r;

	assign ea   = en_r[PIW_E_EA];
	assign lvl0 = timer_and_ext_int_control_r[PIW_T_IT0] ? timer_and_ext_int_control_r[PIW_T_IE0] : (sampling & ~pin_r[0]);
	assign lvl1 = timer_and_ext_int_control_r[PIW_T_IT1] ? timer_and_ext_int_control_r[PIW_T_IE1] : (sampling & ~pin_r[1]);
	assign src  = {flg_r[PIW_F_P1] & en_r[PIW_E_PORT1_CHANGE_IRQ_ENABLE], flg_r[PIW_F_IE2] & en_r[PIW_E_EX2],
		lvl1 & en_r[PIW_E_EX1], lvl0 & en_r[PIW_E_EX0]};
	assign any_irq = ea & ((|src) | core_in.other_irq);
	// Stop wake uses raw pins so a narrow pulse still wakes.
	assign stop_wake = (en_r[PIW_E_EX0] & ~raw[0]) | (en_r[PIW_E_EX1] & ~raw[1])
		| (en_r[PIW_E_EX2] & ~raw[2]) | p1_chg;

	// Port1 change seen during stop is remembered for the warm-up exit.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			p1_wake_r <= 1'b0;
		else if (mode_r == PIW_STOP && p1_chg)
			p1_wake_r <= 1'b1;
		else if (mode_r == PIW_RUN)
			p1_wake_r <= 1'b0;
	end

	// ---------------------------------------------------------------
	// Power modes
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			warm_r <= 16'h0000;
		else if (mode_r == PIW_WARM)
			warm_r <= warm_r + 16'h0001;
		else
			warm_r <= 16'h0000;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_r <= PIW_RUN;
			pwr_r  <= PIW_RST_BYTE;
		end
		else
		begin
			if (wr && idx == PIW_PWR_IDX)
				pwr_r <= wd & PIW_PWR_MASK;
			unique case (mode_r)
				PIW_RUN:
				begin
					if (wr && idx == PIW_PWR_IDX && wd[PIW_PWR_STOP])
						mode_r <= PIW_STOP;
					else if (wr && idx == PIW_PWR_IDX && wd[PIW_PWR_IDLE])
						mode_r <= PIW_IDLE;
				end
				PIW_IDLE:
				begin
					if (any_irq)
					begin
						mode_r <= PIW_RUN;
						pwr_r[PIW_PWR_IDLE] <= 1'b0;
					end
				end
				PIW_STOP:
				begin
					if (stop_wake)
						mode_r <= PIW_WARM;
				end
				PIW_WARM:
				begin
					if (warm_r >= 16'(WARM_CYC - 1))
					begin
						mode_r <= PIW_RUN;
						pwr_r[PIW_PWR_STOP] <= 1'b0;
					end
				end
			endcase
		end
	end

	// Port1 source bit added to irq_src during warm-up for a stop wake by Port1.
	logic p1_late;
	assign p1_late = (mode_r == PIW_WARM) & p1_wake_r;

	// ---------------------------------------------------------------
	// Core outputs
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stat_out <= '0;
		else
		begin
			stat_out.hold    <= (mode_r != PIW_RUN) & ~(mode_r == PIW_IDLE & any_irq);
			stat_out.idle    <= (mode_r == PIW_IDLE);
			stat_out.stop    <= (mode_r == PIW_STOP) | (mode_r == PIW_WARM);
			// Irq not raised in stop or warm-up, so after stop the next instruction runs first.
			stat_out.irq_req <= any_irq & (mode_r != PIW_STOP) & (mode_r != PIW_WARM);
			stat_out.irq_src <= src | {p1_late & ea & en_r[PIW_E_PORT1_CHANGE_IRQ_ENABLE], 3'b000};
		end
	end

	assign clk_run = (mode_r != PIW_STOP);

	// ---------------------------------------------------------------
	// APB read
	// ---------------------------------------------------------------
	logic [7:0] rd;
	logic       hit;

	always_comb
	begin
		rd  = 8'h00;
		hit = 1'b1;
		unique case (idx)
			PIW_PWR_IDX:  rd = pwr_r;
			PIW_TIMER_AND_EXT_INT_CONTROL_IDX: rd = timer_and_ext_int_control_r;
			PIW_FLG_IDX:  rd = flg_r;
			PIW_EN_IDX:   rd = en_r;
			PIW_WK_IDX:   rd = wk_r;
			PIW_ST_IDX:   rd = {6'h00, mode_r};
			default:      hit = 1'b0;
		endcase
		if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00)
			hit = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= {24'h00_0000, rd};
	end

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

endmodule

`default_nettype wire

//--- logic/piw_pkg.sv
// Constants, register map and carrier types of the pin interrupt and wake-up block.
// Assumes a 100 MHz APB clock and byte-wide registers in the low lanes.
// Contract
// - Falling edge on pin one sets its flag
// - Vectoring into service clears the edge flag
// - Trigger select one: level low or falling edge
// - Pin zero trigger select and edge flag
// - Falling edge on pin two sets its flag
// - Flag register: zero clears, one keeps
// - Enabled port1 pin change raises change flag
// - Idle exits only on fully enabled interrupt
// - Idle exit enters service routine at once
// - Power control bit one enters stop
// - Power control bit zero enters idle
// - Pin enables also enable stop wake-up
// - Port1 wake mask enables per-pin wake-up
// - After stop, next instruction before service
// - Stop wake interrupt needs enables and persistence
// - Pin zero sampled only after warm-up
// - Port1 change captured without clock sampling
// - Narrow pulse wakes but raises no interrupt
`default_nettype none

package piw_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] PIW_PWR_IDX  = 8'h87;
	localparam logic [7:0] PIW_TIMER_AND_EXT_INT_CONTROL_IDX = 8'h88;
	localparam logic [7:0] PIW_FLG_IDX  = 8'h95;
	localparam logic [7:0] PIW_EN_IDX   = 8'h40;
	localparam logic [7:0] PIW_WK_IDX   = 8'h41;
	localparam logic [7:0] PIW_ST_IDX   = 8'h42;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int PIW_PWR_IDLE = 0;
	localparam int PIW_PWR_STOP = 1;
	localparam int PIW_T_IT0    = 0;
	localparam int PIW_T_IE0    = 1;
	localparam int PIW_T_IT1    = 2;
	localparam int PIW_T_IE1    = 3;
	localparam int PIW_F_P1     = 1;
	localparam int PIW_F_IE2    = 2;
	localparam int PIW_E_EX0    = 0;
	localparam int PIW_E_EX1    = 1;
	localparam int PIW_E_EX2    = 2;
	localparam int PIW_E_PORT1_CHANGE_IRQ_ENABLE   = 3;
	localparam int PIW_E_EA     = 4;
	localparam int PIW_E_OTHER  = 5;

	// ---------------------------------------------------------------
	// Reset values and timing
	// ---------------------------------------------------------------
	localparam logic [7:0] PIW_RST_BYTE  = 8'h00;
	localparam logic [7:0] PIW_PWR_MASK  = 8'h8F;
	localparam logic [7:0] PIW_FLG_MASK  = 8'h06;
	localparam int         PIW_CLK_MHZ   = 100;
	localparam int         PIW_WARM_US   = 1;
	localparam int         PIW_WARM_CYC  = PIW_WARM_US * PIW_CLK_MHZ;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {PIW_RUN, PIW_IDLE, PIW_STOP, PIW_WARM} piw_mode_e;

	typedef struct packed {
		logic [2:0] vec_ack;
		logic       p1_ack;
		logic       other_irq;
	} piw_core_s;

	typedef struct packed {
		logic       hold;
		logic       idle;
		logic       stop;
		logic       irq_req;
		logic [3:0] irq_src;
	} piw_stat_s;

endpackage

`default_nettype wire

//--- verif/piw_core_model.sv
// Core side model: vectors into the lowest pending pin source once per ack_on.
// Assumes the status carrier of piw_ctrl and one clock.
`timescale 1ns/1ps
`default_nettype none
module piw_core_model
	import piw_pkg::*;
(
	input  wire logic      pclk,
	input  wire logic      presetn,
	input  wire logic      ack_on,
	input  wire logic      other,
	input  wire piw_stat_s stat,
	output piw_core_s      core
);
	logic done;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core <= '0;
			done <= 1'b0;
		end
		else
		begin
			core.other_irq <= other;
			core.vec_ack <= 3'h0;
			core.p1_ack <= 1'b0;
			done <= ack_on && (done || stat.irq_req);
			if (ack_on && !done && stat.irq_req && !stat.hold)
			begin
				core.vec_ack <= stat.irq_src[2:0] & (~stat.irq_src[2:0] + 3'h1);
				core.p1_ack  <= (stat.irq_src[2:0] == 3'h0) & stat.irq_src[3];
			end
		end
	end
endmodule
`default_nettype wire

//--- verif/piw_checker.sv
// Port assertions of the pin interrupt and wake-up block.
// Assumes it is bound into piw_ctrl.
`timescale 1ns/1ps
`default_nettype none
module piw_checker
	import piw_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire piw_core_s   core_in,
	input wire piw_stat_s   stat_out,
	input wire logic        clk_run
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic pw;
	assign pw = psel && penable && pwrite && paddr == 12'h21C;
	property p_stp; pw && pwdata[1] |-> ##[1:3] stat_out.stop; endproperty
	a_stp: assert property (p_stp) else $error("stop not entered");
	property p_idl; pw && pwdata[0] && !stat_out.irq_req |-> ##[1:3] stat_out.idle; endproperty
	a_idl: assert property (p_idl) else $error("idle not entered");
	property p_hld; stat_out.stop |-> stat_out.hold; endproperty
	a_hld: assert property (p_hld) else $error("core runs in stop");
	property p_wrm; $rose(clk_run) |-> stat_out.hold [*2]; endproperty
	a_wrm: assert property (p_wrm) else $error("no warm-up hold");
	property p_gat; !clk_run |-> ##[0:1] stat_out.stop; endproperty
	a_gat: assert property (p_gat) else $error("clock gated outside stop");
	property p_iex; $fell(stat_out.idle) |-> stat_out.irq_req || $past(stat_out.irq_req); endproperty
	a_iex: assert property (p_iex) else $error("idle left without irq");
	property p_now; stat_out.idle && stat_out.irq_req |-> ##[0:2] !stat_out.idle; endproperty
	a_now: assert property (p_now) else $error("idle kept with irq");
	property p_ack; core_in.vec_ack[2] |-> ##[1:2] !stat_out.irq_src[2]; endproperty
	a_ack: assert property (p_ack) else $error("flag kept after vector");
endmodule
bind piw_ctrl piw_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.core_in, .stat_out, .clk_run);
`default_nettype wire

//--- verif/tb_pin_interrupt_wakeup_ctrl.sv
// Self-checking bench of the pin interrupt and wake-up block.
// Assumes piw_pkg, piw_ctrl, piw_core_model and piw_checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_pin_interrupt_wakeup_ctrl import piw_pkg::*;;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, clk_run;
	logic        ext0, ext1, ext2, ack_on, re, oth;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rq;
	logic [7:0]  p1pins;
	piw_core_s   core;
	piw_stat_s   stat;
	int          error_cnt = 0;
	int          n_checks = 0;
	piw_ctrl #(.WARM_CYC(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .ext_pin_zero(ext0), .ext_pin_one(ext1),
		.ext_pin_two(ext2), .port1_pins(p1pins), .core_in(core), .stat_out(stat), .clk_run);
	piw_core_model i_core (.pclk, .presetn, .ack_on, .other(oth), .stat, .core);
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic results;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input string s, input logic [7:0] i, input logic [7:0] e);
		repeat (8) @(posedge pclk);
		apb(1'b0, i, 8'h00);
		chk(s, e, rq[7:0]);
	endtask
	task automatic ack;
		ack_on <= 1'b1;
		repeat (4) @(posedge pclk);
		ack_on <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
	task automatic wake;
		for (int n = 0; n < 100 && clk_run !== 1'b1; n++)
			@(posedge pclk);
		for (int n = 0; n < 100 && stat.hold !== 1'b0; n++)
			@(posedge pclk);
		chk("hold", 8'h00, {7'h00, stat.hold});
		repeat (3) @(posedge pclk);
	endtask
	task automatic t_regs;
		rc("timer_and_ext_int_control", PIW_TIMER_AND_EXT_INT_CONTROL_IDX, 8'h00);
		rc("flags", PIW_FLG_IDX, 8'h00);
		apb(1'b0, 8'hFF, 8'h00);
		chk("slverr", 8'h01, {7'h00, re});
		apb(1'b1, PIW_TIMER_AND_EXT_INT_CONTROL_IDX, 8'h05);
		rc("tsel", PIW_TIMER_AND_EXT_INT_CONTROL_IDX, 8'h05);
	endtask
	task automatic t_edge;
		apb(1'b1, PIW_EN_IDX, 8'h07);
		apb(1'b1, PIW_WK_IDX, 8'h01);
		{ext2, ext1, ext0} <= 3'h0;
		p1pins <= 8'h01;
		rc("edge01", PIW_TIMER_AND_EXT_INT_CONTROL_IDX, 8'h0F);
		rc("edge2p1", PIW_FLG_IDX, 8'h06);
		{ext2, ext1, ext0} <= 3'h7;
		p1pins <= 8'h00;
		repeat (8) @(posedge pclk);
		apb(1'b1, PIW_FLG_IDX, 8'hFB);
		rc("clr2", PIW_FLG_IDX, 8'h02);
		apb(1'b1, PIW_FLG_IDX, 8'hFD);
		rc("clrp1", PIW_FLG_IDX, 8'h00);
		apb(1'b1, PIW_EN_IDX, 8'h17);
		ack();
		ack();
		rc("ackclr", PIW_TIMER_AND_EXT_INT_CONTROL_IDX, 8'h05);
		apb(1'b1, PIW_TIMER_AND_EXT_INT_CONTROL_IDX, 8'h00);
		ext1 <= 1'b0;
		repeat (8) @(posedge pclk);
		chk("lvl1", 8'h02, {4'h0, stat.irq_src} & 8'h02);
		ext1 <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("lvl1off", 8'h00, {4'h0, stat.irq_src} & 8'h02);
		apb(1'b1, PIW_TIMER_AND_EXT_INT_CONTROL_IDX, 8'h05);
	endtask
	task automatic t_idle;
		apb(1'b1, PIW_EN_IDX, 8'h04);
		apb(1'b1, PIW_PWR_IDX, 8'h01);
		ext2 <= 1'b0;
		repeat (10) @(posedge pclk);
		chk("idle", 8'h01, {7'h00, stat.idle});
		apb(1'b1, PIW_EN_IDX, 8'h14);
		repeat (3) @(posedge pclk);
		chk("wake", 8'h01, {7'h00, !stat.idle && stat.irq_req});
		ext2 <= 1'b1;
		ack();
		chk("ack2", 8'h00, {4'h0, stat.irq_src});
		apb(1'b1, PIW_EN_IDX, 8'h00);
		apb(1'b1, PIW_PWR_IDX, 8'h01);
		oth <= 1'b1;
		repeat (10) @(posedge pclk);
		chk("oidle", 8'h01, {7'h00, stat.idle});
		apb(1'b1, PIW_EN_IDX, 8'h10);
		repeat (3) @(posedge pclk);
		chk("owake", 8'h00, {7'h00, stat.idle});
		oth <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task automatic t_stop;
		apb(1'b1, PIW_EN_IDX, 8'h18);
		apb(1'b1, PIW_WK_IDX, 8'h02);
		apb(1'b1, PIW_PWR_IDX, 8'h02);
		repeat (3) @(posedge pclk);
		p1pins <= 8'h04;
		repeat (10) @(posedge pclk);
		chk("stop", 8'h00, {7'h00, clk_run});
		p1pins <= 8'h06;
		wake();
		chk("p1irq", 8'h08, {4'h0, stat.irq_src});
		ack();
		chk("p1ack", 8'h00, {4'h0, stat.irq_src});
		p1pins <= 8'h00;
		apb(1'b1, PIW_WK_IDX, 8'h00);
		apb(1'b1, PIW_FLG_IDX, 8'hFD);
	endtask
	task automatic t_narrow;
		apb(1'b1, PIW_EN_IDX, 8'h11);
		apb(1'b1, PIW_PWR_IDX, 8'h02);
		repeat (3) @(posedge pclk);
		ext0 <= 1'b0;
		repeat (3) @(posedge pclk);
		ext0 <= 1'b1;
		wake();
		chk("nwake", 8'h01, {7'h00, clk_run});
		chk("narrow", 8'h00, {4'h0, stat.irq_src});
		rc("nflag", PIW_TIMER_AND_EXT_INT_CONTROL_IDX, 8'h05);
	endtask
	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, ack_on, oth} = 5'h00;
		{ext2, ext1, ext0} = 3'h7;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		p1pins = 8'h00;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_edge();
		t_idle();
		t_stop();
		t_narrow();
		results();
	end
	initial
	begin
		#200000;
		error_cnt++;
		results();
	end
endmodule
`default_nettype wire
